/* File: verilog/amb_core.sv */
/*
  Control core of a three-axis acceleration sensor: start-up load with
  checksum, measurement modes, motion and free-fall detection, interrupt,
  temperature and sample ring buffer, all behind an Avalon-MM slave.
  Assumes sensor pins change away from the rising edge of SAMPLE_CLK.
*/
// Notes on behaviour
// - reset leaves normal mode, data always readable
// - motion in motion mode raises interrupt
// - per-axis threshold, enable-any and require-all trigger
// - detected motion direction held for reading
// - motion mode freezes acceleration results
// - enabled free-fall detection raises interrupt
// - free-fall runs beside measurement
// - interrupt only from enabled sources
// - interrupt source readable in interrupt source register
// - nine-bit temperature readable
// - buffer returns oldest of 64 first
// - independent read and write pointers
// - full buffer overwrites the oldest sample
// - interrupt at half or three-quarter fill
// - repeated reads drain buffer back to back
// - samples enter at sensor rate only
// - load calibration from non-volatile store
// - checksum sets or clears error flag
// - data flows to outputs, valid after turn-on
// - bypass mode skips low-pass filter
// - option one bypass/narrow/absent, option two wide
// - codes 010 and 001 pick option modes
// - code 011 picks motion detection
// - narrow band filters harder, halves rate
`include "amb_defines.svh"
`timescale 1ns/100ps
module amb_core
  import amb_pkg::*;
#(
  parameter int   DEPTH     = 64,
  parameter int   OPT1_KIND = 1,
  parameter bit   OPT2_EN   = 1'b0,
  parameter bit   TEMP_EN   = 1'b1
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // avalon-mm slave
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // sensor pins
  input  wire logic        SAMPLE_CLK,
  input  wire amb_axes_t   ACC_IN,
  input  wire logic [8:0]  TEMP_IN,
  // non-volatile store
  output logic      [1:0]  NVM_ADDR,
  output logic             NVM_RD,
  input  wire logic [7:0]  NVM_DATA,
  // interrupt
  output logic             INT
);
  localparam int AW = $clog2(DEPTH);

  amb_pins_t    pins;
  logic         clk_d;
  logic         tick;
  amb_load_t    ld_state;
  logic [1:0]   ld_idx;
  logic [1:0]   ld_lat;
  logic [7:0]   ld_sum;
  logic [7:0]   cal [3];
  logic         loaded;
  logic         checksum_error_flag;
  amb_mode_t    mode;
  logic         ff_en;
  logic         buf_en;
  logic         buf_q;
  logic [2:0]   int_en;
  logic [2:0]   int_src;
  logic [2:0]   md_en;
  logic [2:0]   md_req;
  logic [7:0]   md_th [3];
  logic [2:0]   md_dir;
  amb_smp_t     ff_th;
  amb_axes_t    acc;
  amb_axes_t    base;
  amb_axes_t    raw;
  amb_axes_t    next_acc;
  amb_axes_t    next_base;
  logic [2:0]   hit;
  logic [2:0]   low;
  logic [2:0]   shift;
  logic [8:0]   temp;
  logic         dec;
  logic [7:0]   valid_cnt;
  logic [3:0]   ff_cnt;
  logic         md;
  logic         upd;
  logic         md_evt;
  logic         ff_evt;
  logic         buf_evt;
  logic         above;
  logic         above_d;
  logic [1:0]   buf_axis;
  logic [38:0]  buf_rdata;
  logic [AW:0]  buf_count;
  logic         buf_pop;
  logic         acc_req;
  logic [31:0]  rdata;

  // ****************************************
  // pin capture and sample tick
  // ****************************************
  amb_sync2 #(.W($bits(amb_pins_t))) u_sync (
    .clk (CLK),
    .d   ({SAMPLE_CLK, ACC_IN, TEMP_IN, NVM_DATA}),
    .q   (pins)
  );

  always_ff @(posedge CLK) begin
    clk_d <= RST ? 1'b0 : pins.clk;
  end
  // samples advance on the sensor clock only, never on bus traffic
  assign tick = pins.clk && !clk_d;

  // ****************************************
  // start-up load and checksum
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      ld_state <= LD_REQ;
      ld_idx   <= 2'h0;
      ld_lat   <= 2'h0;
      ld_sum   <= 8'h00;
      NVM_RD   <= 1'b0;
      NVM_ADDR <= 2'h0;
      loaded   <= 1'b0;
      checksum_error_flag     <= 1'b0;
    end else begin
      unique case (ld_state)
        LD_REQ: begin
          NVM_RD   <= 1'b1;
          NVM_ADDR <= ld_idx;
          ld_lat   <= 2'h0;
          ld_state <= LD_WAIT;
        end
        LD_WAIT: begin
          ld_lat <= ld_lat + 1'b1;
          if (ld_lat == `AMB_NVM_LAT) begin
            if (ld_idx == `AMB_NVM_LAST) begin
              checksum_error_flag     <= ld_sum != pins.nvm;
              loaded   <= 1'b1;
              NVM_RD   <= 1'b0;
              ld_state <= LD_DONE;
            end else begin
              ld_sum   <= ld_sum + pins.nvm;
              ld_idx   <= ld_idx + 1'b1;
              ld_state <= LD_REQ;
            end
          end
        end
        LD_DONE: ld_state <= LD_DONE;
        default: ld_state <= LD_REQ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cal <= '{default: 8'h00};
    end else if (ld_state == LD_WAIT && ld_lat == `AMB_NVM_LAT && ld_idx != `AMB_NVM_LAST) begin
      cal[ld_idx] <= pins.nvm;
    end
  end

  // ****************************************
  // signal channel
  // ****************************************
  function automatic amb_smp_t lp(amb_smp_t p, amb_smp_t x, logic [2:0] sh);
    logic signed [13:0] d;
    d = 14'(x) - 14'(p);
    return amb_smp_t'(p + 13'(d >>> sh));
  endfunction : lp

  function automatic logic [12:0] mag(amb_smp_t v);
    return v[12] ? 13'(-v) : 13'(v);
  endfunction : mag

  assign md = mode == AMB_MOTION;

  always_comb begin
    shift = `AMB_LP_SHIFT;
    unique case (mode)
      AMB_OPT1:   shift = (OPT1_KIND == 2) ? `AMB_NB_SHIFT : `AMB_LP_SHIFT;
      AMB_OPT2:   shift = `AMB_WB_SHIFT;
      AMB_NORMAL: shift = `AMB_LP_SHIFT;
      AMB_MOTION: shift = `AMB_LP_SHIFT;
    endcase
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      raw[i]       = amb_smp_t'(pins.acc[i] + {{5{cal[i][7]}}, cal[i]});
      next_base[i] = lp(base[i], raw[i], `AMB_BASE_SHIFT);
      if (mode == AMB_OPT1 && OPT1_KIND == 1) begin
        next_acc[i] = raw[i];
      end else begin
        next_acc[i] = lp(acc[i], raw[i], shift);
      end
      hit[i] = mag(amb_smp_t'(raw[i] - base[i])) > {5'h00, md_th[i]};
      low[i] = mag(raw[i]) < 13'(ff_th);
    end
  end

  // narrow band keeps every second result
  assign upd = tick && loaded && !md && !(mode == AMB_OPT1 && OPT1_KIND == 2 && dec);

  always_ff @(posedge CLK) begin
    if (RST) begin
      acc       <= '0;
      base      <= '0;
      dec       <= 1'b0;
      valid_cnt <= 8'h00;
      temp      <= 9'h000;
    end else if (tick && loaded) begin
      dec <= ~dec;
      if (TEMP_EN) begin
        temp <= pins.temp;
      end
      if (md) begin
        base <= next_base;
      end else if (upd) begin
        acc <= next_acc;
        if (valid_cnt != `AMB_TURNON) begin
          valid_cnt <= valid_cnt + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // motion and free-fall detection
  // ****************************************
  assign md_evt = tick && loaded && md && |(hit & md_en)
                  && ((hit & md_req) == md_req);

  always_ff @(posedge CLK) begin
    if (RST) begin
      md_dir <= 3'h0;
    end else if (md_evt) begin
      md_dir <= hit;
    end
  end

  // free-fall watches the same samples, so measurement keeps running
  assign ff_evt = tick && loaded && ff_en && !md && &low
                  && ff_cnt == `AMB_FF_SAMPLES - 1'b1;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ff_cnt <= 4'h0;
    end else if (tick && loaded) begin
      if (!ff_en || md || !(&low)) begin
        ff_cnt <= 4'h0;
      end else if (ff_cnt != `AMB_FF_SAMPLES) begin
        ff_cnt <= ff_cnt + 1'b1;
      end
    end
  end

  // ****************************************
  // ring buffer
  // ****************************************
  amb_ring #(.W(39), .DEPTH(DEPTH)) u_ring (
    .clk   (CLK),
    .rst   (RST),
    .push  (upd && buf_en),
    .wdata (next_acc),
    .pop   (buf_pop),
    .rdata (buf_rdata),
    .count (buf_count)
  );

  assign above   = buf_count >= (buf_q ? (AW+1)'(DEPTH * 3 / 4) : (AW+1)'(DEPTH / 2));
  assign buf_evt = above && !above_d;
  assign acc_req = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  assign buf_pop = acc_req && AVS_READ && AVS_ADDRESS == `AMB_OFS_BUFDATA
                   && buf_axis == 2'h2;

  always_ff @(posedge CLK) begin
    if (RST) begin
      above_d  <= 1'b0;
      buf_axis <= 2'h0;
    end else begin
      above_d <= above;
      if (acc_req && AVS_READ && AVS_ADDRESS == `AMB_OFS_BUFDATA && buf_count != '0) begin
        buf_axis <= (buf_axis == 2'h2) ? 2'h0 : buf_axis + 1'b1;
      end
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      int_src <= 3'h0;
      INT     <= 1'b0;
    end else begin
      // a new event wins over the clear of a source read
      int_src <= (int_src & ((acc_req && AVS_READ && AVS_ADDRESS == `AMB_OFS_INTSRC)
                 ? 3'h0 : 3'h7)) | ({buf_evt, ff_evt, md_evt} & int_en);
      INT     <= |(int_src & int_en);
    end
  end

  // ****************************************
  // register file
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      mode   <= AMB_NORMAL;
      ff_en  <= 1'b0;
      buf_en <= 1'b0;
      buf_q  <= 1'b0;
      int_en <= 3'h0;
      md_en  <= 3'h0;
      md_req <= 3'h0;
      md_th  <= '{default: `AMB_MD_TH_RST};
      ff_th  <= `AMB_FF_TH_RST;
    end else if (acc_req && AVS_WRITE) begin
      unique case (AVS_ADDRESS)
        `AMB_OFS_MODE: begin
          // unavailable option codes are ignored, mode stays
          if (AVS_WRITEDATA[2:0] == AMB_NORMAL || AVS_WRITEDATA[2:0] == AMB_MOTION
              || (AVS_WRITEDATA[2:0] == AMB_OPT1 && OPT1_KIND != 0)
              || (AVS_WRITEDATA[2:0] == AMB_OPT2 && OPT2_EN)) begin
            mode <= amb_mode_t'(AVS_WRITEDATA[2:0]);
          end
          ff_en  <= AVS_WRITEDATA[`AMB_MODE_FFD];
          buf_en <= AVS_WRITEDATA[`AMB_MODE_BUFEN];
          buf_q  <= AVS_WRITEDATA[`AMB_MODE_BUFQ];
        end
        `AMB_OFS_INTEN:  int_en <= AVS_WRITEDATA[2:0];
        `AMB_OFS_MDCTRL: begin
          md_en  <= AVS_WRITEDATA[2:0];
          md_req <= AVS_WRITEDATA[5:3];
        end
        `AMB_OFS_MDTH: begin
          for (int i = 0; i < 3; i++) begin
            md_th[i] <= AVS_WRITEDATA[8*i +: 8];
          end
        end
        `AMB_OFS_FFTH:   ff_th <= AVS_WRITEDATA[12:0];
        default:         ff_th <= ff_th;
      endcase
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      `AMB_OFS_STATUS:  rdata = {29'h0, valid_cnt == `AMB_TURNON, loaded, checksum_error_flag};
      `AMB_OFS_MODE:    rdata = {26'h0, buf_q, buf_en, ff_en, mode};
      `AMB_OFS_X:       rdata = {19'h0, acc[0]};
      `AMB_OFS_Y:       rdata = {19'h0, acc[1]};
      `AMB_OFS_Z:       rdata = {19'h0, acc[2]};
      `AMB_OFS_TEMP:    rdata = {23'h0, temp};
      `AMB_OFS_BUFDATA: rdata = (buf_count == '0 || md) ? 32'h0 : {19'h0, buf_rdata[13*buf_axis +: 13]};
      `AMB_OFS_BUFCNT:  rdata = 32'(buf_count);
      `AMB_OFS_INTEN:   rdata = {29'h0, int_en};
      `AMB_OFS_INTSRC:  rdata = {29'h0, int_src};
      `AMB_OFS_MDCTRL:  rdata = {26'h0, md_req, md_en};
      `AMB_OFS_MDTH:    rdata = {8'h0, md_th[2], md_th[1], md_th[0]};
      `AMB_OFS_MDDIR:   rdata = {29'h0, md_dir};
      `AMB_OFS_FFTH:    rdata = {19'h0, ff_th};
      default:          rdata = 32'h0000_0000;
    endcase
  end

  // one wait cycle on every access, answer in the next
  always_ff @(posedge CLK) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= !acc_req;
      if (acc_req && AVS_READ) begin
        AVS_READDATA <= rdata;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ack;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  a_bus_answer: assert property (s_req |=> s_ack) else $error("bus answer late");
  a_int_enabled: assert property (INT |-> $past(|(int_src & int_en)))
    else $error("interrupt without enabled source");
  a_motion_int: assert property (md_evt && int_en[0] |-> ##2 INT)
    else $error("motion interrupt missing");
  a_ff_int: assert property (ff_evt && int_en[1] |-> ##2 INT)
    else $error("free-fall interrupt missing");
  a_dir_held: assert property (md_evt |=> md_dir == $past(hit))
    else $error("motion direction not held");
  a_md_frozen: assert property (md && !$past(RST) |=> $stable(acc))
    else $error("results move in motion mode");
  a_src_clear: assert property (acc_req && AVS_READ && AVS_ADDRESS == `AMB_OFS_INTSRC
    && !md_evt && !ff_evt && !buf_evt |=> int_src == 3'h0)
    else $error("source not cleared on read");
  a_csum_flag: assert property ($rose(loaded) |-> checksum_error_flag == ($past(ld_sum) != $past(pins.nvm)))
    else $error("checksum flag wrong");
  a_buf_full: assert property (buf_count == (AW+1)'(DEPTH) && upd && buf_en && !buf_pop
    |=> buf_count == (AW+1)'(DEPTH)) else $error("overflow changed fill");
endmodule : amb_core

/* File: verilog/amb_defines.svh */
/*
  Register offsets, field positions, reset values and counts of the
  acceleration mode and buffer core. Assumes byte addressing, one word per register.
*/
`ifndef AMB_DEFINES_SVH
`define AMB_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define AMB_OFS_STATUS   6'h00
`define AMB_OFS_MODE     6'h04
`define AMB_OFS_X        6'h08
`define AMB_OFS_Y        6'h0c
`define AMB_OFS_Z        6'h10
`define AMB_OFS_TEMP     6'h14
`define AMB_OFS_BUFDATA  6'h18
`define AMB_OFS_BUFCNT   6'h1c
`define AMB_OFS_INTEN    6'h20
`define AMB_OFS_INTSRC   6'h24
`define AMB_OFS_MDCTRL   6'h28
`define AMB_OFS_MDTH     6'h2c
`define AMB_OFS_MDDIR    6'h30
`define AMB_OFS_FFTH     6'h34

// ****************************************
// field positions
// ****************************************
`define AMB_ST_CHECKSUM_ERROR_FLAG      0
`define AMB_ST_LOADED    1
`define AMB_ST_VALID     2
`define AMB_MODE_FFD     3
`define AMB_MODE_BUFEN   4
`define AMB_MODE_BUFQ    5
`define AMB_SRC_MOTION   0
`define AMB_SRC_FF       1
`define AMB_SRC_BUF      2

// ****************************************
// reset values and counts
// ****************************************
`define AMB_FF_TH_RST    13'h00c8
`define AMB_MD_TH_RST    8'h40
`define AMB_NVM_LAST     2'h3
`define AMB_NVM_LAT      2'h3
`define AMB_TURNON       8'h10
`define AMB_FF_SAMPLES   4'h4
`define AMB_LP_SHIFT     3'h2
`define AMB_NB_SHIFT     3'h3
`define AMB_WB_SHIFT     3'h1
`define AMB_BASE_SHIFT   3'h4

`endif

/* File: verilog/amb_pkg.sv */
/*
  Types of the acceleration mode and buffer core.
  Assumes the defines header is compiled alongside.
*/
package amb_pkg;

  typedef logic signed [12:0] amb_smp_t;
  typedef amb_smp_t [2:0]     amb_axes_t;

  typedef struct packed {
    logic       clk;
    amb_axes_t  acc;
    logic [8:0] temp;
    logic [7:0] nvm;
  } amb_pins_t;

  typedef enum logic [2:0] {
    AMB_NORMAL = 3'b000,
    AMB_OPT2   = 3'b001,
    AMB_OPT1   = 3'b010,
    AMB_MOTION = 3'b011
  } amb_mode_t;

  typedef enum logic [1:0] {
    LD_REQ  = 2'b00,
    LD_WAIT = 2'b01,
    LD_DONE = 2'b10
  } amb_load_t;

endpackage : amb_pkg

/* File: verilog/amb_sync2.sv */
/*
  Two flip-flop synchroniser for a bundle of pin levels.
  Assumes bits of the bundle are sampled only when stable.
*/
`timescale 1ns/100ps
module amb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule : amb_sync2

/* File: verilog/amb_ring.sv */
/*
  Ring buffer with separate read and write pointers; a push into a full
  buffer drops the oldest entry. Assumes DEPTH is a power of two.
*/
`timescale 1ns/100ps
module amb_ring #(
  parameter int W     = 39,
  parameter int DEPTH = 64,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          push,
  input  wire logic [W-1:0]  wdata,
  input  wire logic          pop,
  output logic      [W-1:0]  rdata,
  output logic      [AW:0]   count
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic          full;
  logic          take;

  assign full  = count == (AW+1)'(DEPTH);
  assign take  = pop && count != '0;
  assign rdata = mem[rptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (take || (push && full)) begin
        rptr <= rptr + 1'b1;
      end
      if (push && !full && !take) begin
        count <= count + 1'b1;
      end else if (take && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : amb_ring

/* File: verif/amb_sensor_model.sv */
/*
  Model of the sensor front end and the non-volatile store facing amb_core.
  Assumes the bench moves base, ramp and run only on core clock edges.
*/
`timescale 1ns/100ps
module amb_sensor_model
  import amb_pkg::*;
(
  // controls from the bench
  input  wire logic        run,
  input  wire logic        ramp,
  input  wire logic        bad,
  input  wire amb_axes_t   base,
  input  wire logic [8:0]  temp,
  input  wire logic [1:0]  nvm_addr,
  // pins toward the core
  output amb_pins_t        pins,
  output logic      [12:0] seq
);
  logic      sclk;
  amb_axes_t acc;

  // ****************************************
  // sample clock, phase unrelated to core clock
  // ****************************************
  initial begin
    sclk = 1'b0;
    seq  = 13'h0;
    #3;
    forever begin
      #40;
      if (run) sclk = 1'b1;
      #40;
      // values move on the fall, far from the sampled rise
      if (sclk) begin
        sclk = 1'b0;
        seq  = seq + 13'h1;
      end
    end
  end

  // ****************************************
  // pin values and store words
  // ****************************************
  always_comb begin
    for (int k = 0; k < 3; k++) acc[k] = base[k] + (ramp ? amb_smp_t'(seq) : 13'sh0);
    pins.clk  = sclk;
    pins.acc  = acc;
    pins.temp = temp;
    // offsets all zero, so a good sum word is zero too
    pins.nvm  = (nvm_addr == 2'h3) ? {7'h0, bad} : 8'h00;
  end
endmodule : amb_sensor_model

/* File: verif/amb_core_tb.sv */
/*
  Self-checking bench of amb_core: Avalon-MM master tasks, queue of expected reads.
  Assumes the package, the defines header and the sensor model are compiled first.
*/
`include "amb_defines.svh"
`timescale 1ns/100ps
module amb_core_tb
  import amb_pkg::*;
;
  typedef struct packed { logic [31:0] v; logic [31:0] m; } amb_note_t;
  logic        CLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, INT, NVM_RD;
  logic [5:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, r;
  logic [1:0]  NVM_ADDR;
  logic        part_run, part_ramp, part_bad;
  amb_axes_t   part_base;
  logic [8:0]  part_temp;
  logic [12:0] seq, s, x;
  amb_pins_t   pins;
  amb_note_t   notes[$];
  amb_note_t   nt;
  int          fail_count, checks, seed, i, j;

  amb_core i_amb_core (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .SAMPLE_CLK(pins.clk), .ACC_IN(pins.acc),
    .TEMP_IN(pins.temp), .NVM_ADDR(NVM_ADDR), .NVM_RD(NVM_RD), .NVM_DATA(pins.nvm), .INT(INT));
  amb_sensor_model i_amb_sensor_model (.run(part_run), .ramp(part_ramp), .bad(part_bad),
    .base(part_base), .temp(part_temp), .nvm_addr(NVM_ADDR), .pins(pins), .seq(seq));

  // ****************************************
  // compare, report and bus tasks
  // ****************************************
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks++;
    if ((got & m) !== (exp & m)) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic to_fail;
    fail_count++;
    close_out;
  endtask : to_fail
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    int n;
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    AVS_WRITEDATA <= d;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    if (n >= 50) to_fail;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
    // waitrequest is back high one edge later
    @(posedge CLK);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    notes.push_back('{v: e, m: m});
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic wait_int(input logic lvl);
    int n;
    n = 0;
    while (INT !== lvl && n < 400) begin
      @(posedge CLK);
      n++;
    end
    cmp_bit(INT, lvl);
    if (n >= 400) close_out;
  endtask : wait_int
  task automatic wait_smp(input logic [12:0] n);
    int k;
    s = seq + n;
    k = 0;
    while (seq !== s && k < 3000) begin
      @(posedge CLK);
      k++;
    end
    if (k >= 3000) to_fail;
  endtask : wait_smp

  // ****************************************
  // clock, watchdog and read monitor
  // ****************************************
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    #400000;
    to_fail;
  end
  always @(posedge CLK) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
      nt = notes.pop_front();
      cmp_val(AVS_READDATA, nt.v, nt.m);
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed = 32'h0268;
    {RST, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = {1'b1, 40'h0};
    {part_run, part_ramp, part_bad, part_base, part_temp} = {1'b1, 50'h0};
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    cmp_bit(AVS_WAITREQUEST, 1'b1);
    cmp_bit(INT, 1'b0);
    repeat (30) @(posedge CLK);
    rd(`AMB_OFS_STATUS, 32'h2, 32'h3);
    rd(`AMB_OFS_MODE, 32'h0);
    rd(6'h3c, 32'h0);
    $display("test reset done");
    for (i = 0; i < 3; i++) begin
      r = $random(seed);
      part_base[i] <= {{3{r[9]}}, r[9:0]};
    end
    r = $random(seed);
    part_temp <= r[8:0];
    wr(`AMB_OFS_MODE, 32'h2);
    wait_smp(20);
    rd(`AMB_OFS_STATUS, 32'h4, 32'h4);
    for (i = 0; i < 3; i++) rd(`AMB_OFS_X + 6'(4 * i), {19'h0, part_base[i]});
    rd(`AMB_OFS_TEMP, {23'h0, part_temp});
    wr(`AMB_OFS_MODE, 32'h9);
    rd(`AMB_OFS_MODE, 32'ha);
    $display("test modes done");
    part_base <= '0;
    wait_smp(8);
    cmp_bit(INT, 1'b0);
    rd(`AMB_OFS_INTSRC, 32'h0);
    rd(`AMB_OFS_X, 32'h0);
    part_base[0] <= 13'sh400;
    wait_smp(6);
    wr(`AMB_OFS_INTEN, 32'h2);
    part_base[0] <= 13'sh0;
    wait_int(1'b1);
    rd(`AMB_OFS_INTSRC, 32'h2);
    wait_int(1'b0);
    $display("test free fall done");
    wr(`AMB_OFS_INTEN, 32'h4);
    part_ramp <= 1'b1;
    part_base <= {13'sh200, 13'sh100, 13'sh0};
    wr(`AMB_OFS_MODE, 32'h12);
    wait_int(1'b1);
    rd(`AMB_OFS_INTSRC, 32'h4);
    wait_smp(80);
    part_run <= 1'b0;
    repeat (50) @(posedge CLK);
    rd(`AMB_OFS_BUFCNT, 32'd64);
    for (i = 0; i < 64; i++) begin
      x = seq - 13'd64 + 13'(i);
      for (j = 0; j < 3; j++) rd(`AMB_OFS_BUFDATA, {19'h0, part_base[j] + x});
    end
    rd(`AMB_OFS_BUFCNT, 32'h0);
    rd(`AMB_OFS_BUFDATA, 32'h0);
    x = seq;
    part_run <= 1'b1;
    wait_smp(3);
    for (j = 0; j < 3; j++) rd(`AMB_OFS_BUFDATA, {19'h0, part_base[j] + x});
    $display("test buffer done");
    part_ramp <= 1'b0;
    wr(`AMB_OFS_MODE, 32'h2);
    part_base <= {3{13'sh10}};
    wait_smp(6);
    rd(`AMB_OFS_X, 32'h10);
    wr(`AMB_OFS_INTEN, 32'h1);
    wr(`AMB_OFS_MDCTRL, 32'h1);
    wr(`AMB_OFS_MODE, 32'h3);
    part_base[0] <= 13'sh20;
    wait_smp(6);
    rd(`AMB_OFS_X, 32'h10);
    rd(`AMB_OFS_BUFDATA, 32'h0);
    part_base[1] <= 13'sh500;
    wait_smp(6);
    cmp_bit(INT, 1'b0);
    part_base[0] <= 13'sh600;
    wait_int(1'b1);
    rd(`AMB_OFS_MDDIR, 32'h1, 32'h1);
    // the slow baseline keeps the trigger alive for many samples, so leave the
    // mode first; the latched source must then still hold the pin up
    wr(`AMB_OFS_MODE, 32'h2);
    cmp_bit(INT, 1'b1);
    rd(`AMB_OFS_INTSRC, 32'h1);
    wait_int(1'b0);
    $display("test motion done");
    part_bad <= 1'b1;
    RST <= 1'b1;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    repeat (30) @(posedge CLK);
    rd(`AMB_OFS_STATUS, 32'h3, 32'h3);
    $display("test checksum done");
    close_out;
  end
endmodule : amb_core_tb
